// ### hw/iops_top.v
// I/O ports with alternate pin function steering
`timescale 1ns/100ps
`include "iops_defines.vh"
module iops_top (
  input wire clk_in,
  input wire sys_rst_in,
  input wire clk_en_in,
  input wire [4:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire [39:0] pin_i_in,
  output wire [39:0] pin_o_out,
  output wire [39:0] pin_oe_out,
  input wire pwm_b_en_in,
  input wire pwm_b_output_in,
  input wire cmp2_en_in,
  input wire cmp2_output_in,
  input wire cmp3_en_in,
  input wire cmp3_output_in,
  input wire latch_inv_en_in,
  input wire latch_inverted_output_in,
  input wire comparator2_en_in,
  input wire comparator2_output_in,
  output wire slave_select_n_out,
  output wire timer_gate_input_out,
  output wire cmp2_capture_out,
  output wire cmp3_capture_out,
  output wire [7:0] alt_pin_function_select_out
);
  localparam W = `IOPS_NUM_PORTS * `IOPS_PORT_W;

  // Flat views of the per-port banks, bit = port*8 + pin
  wire [W-1:0] dir_all;
  wire [W-1:0] lat_all;
  wire [W-1:0] ans_all;
  reg [7:0] rdata_next;
  reg [7:0] alt_pin_function_select;
  reg [W-1:0] ovr_en;
  reg [W-1:0] ovr_val;
  wire [W-1:0] pin_sync;
  wire [W-1:0] dig_in;
  wire [2:0] port_idx;
  wire [1:0] reg_sel;
  wire port_hit;

  assign port_idx = addr_in[4:2];
  assign reg_sel = addr_in[1:0];
  // Ports A..E occupy 0x00..0x13
  assign port_hit = (port_idx < 3'd5);

  // Select bits; each note gives the pin for one / for zero
  // Capture/compare 2: B3 / C1
  wire cmp2_pin_choice = alt_pin_function_select[`IOPS_SEL_CMP2];
  // Slave select input: A0 / A5
  wire slave_select_pin_choice = alt_pin_function_select[`IOPS_SEL_SS];
  // Comparator 2 output: A0 / A5
  wire comparator2_out_pin_choice = alt_pin_function_select[`IOPS_SEL_COMPARATOR2_OUTPUT];
  // Latch inverted output: A0 / A5
  wire latch_inv_out_pin_choice = alt_pin_function_select[`IOPS_SEL_LNQ];
  // PWM B output: B5 / C0
  wire pwm_b_pin_choice = alt_pin_function_select[`IOPS_SEL_PWMB];
  // Timer gate input: C4 / B5
  wire timer_gate_pin_choice = alt_pin_function_select[`IOPS_SEL_TGATE];
  // Capture/compare 3: B5 / C0
  wire cmp3_pin_choice = alt_pin_function_select[`IOPS_SEL_CMP3];

  // Per-port register banks; each port decodes its own base address
  genvar p;
  generate
    for (p = 0; p < `IOPS_NUM_PORTS; p = p + 1) begin : g_port
      reg [7:0] dir_reg;
      reg [7:0] lat_reg;
      reg [7:0] ans_reg;
      wire port_wr = clk_en_in && wr_in && ({29'h0, port_idx} == p);
      always @(posedge clk_in) begin
        if (sys_rst_in) begin
          dir_reg <= `IOPS_DIR_RST;
          lat_reg <= `IOPS_LAT_RST;
          ans_reg <= `IOPS_ANS_RST;
        end else if (port_wr) begin
          case (reg_sel)
            `IOPS_OFS_PIN, `IOPS_OFS_LAT: begin
              // No read-modify-write: pin-level writes land in the latch
              lat_reg <= wdata_in;
            end
            `IOPS_OFS_DIR: begin
              dir_reg <= wdata_in;
            end
            default: begin
              ans_reg <= wdata_in;
            end
          endcase
        end
      end
      assign dir_all[p*8 +: 8] = dir_reg;
      assign lat_all[p*8 +: 8] = lat_reg;
      assign ans_all[p*8 +: 8] = ans_reg;
    end
  endgenerate

  // Steering register; it never touches any direction bit
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      alt_pin_function_select <= `IOPS_ALTSEL_RST;
    end else if (clk_en_in && wr_in && addr_in == `IOPS_ADDR_ALTSEL) begin
      // Top bit is unimplemented and stays zero
      alt_pin_function_select <= wdata_in & `IOPS_ALTSEL_MASK;
    end
  end

  // Read mux. Pin levels lag the pins by two edges, so a read right
  // after a direction change may still show the old level.
  always @* begin
    rdata_next = 8'h00;
    if (rd_in && port_hit) begin
      case (reg_sel)
        `IOPS_OFS_PIN: begin
          rdata_next = dig_in[port_idx*8 +: 8];
        end
        `IOPS_OFS_DIR: begin
          rdata_next = dir_all[port_idx*8 +: 8];
        end
        `IOPS_OFS_LAT: begin
          rdata_next = lat_all[port_idx*8 +: 8];
        end
        default: begin
          rdata_next = ans_all[port_idx*8 +: 8];
        end
      endcase
    end else if (rd_in && addr_in == `IOPS_ADDR_ALTSEL) begin
      rdata_next = alt_pin_function_select;
    end
  end

  // Read data, one cycle after the strobe; zero in every other enabled cycle, held while clk_en_in is low
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_out <= 8'h00;
    end else if (clk_en_in) begin
      rdata_out <= rdata_next;
    end
  end

  // Each enabled output function is decoded onto exactly one of its two candidate pins
  wire comparator2_output_on_a0 = comparator2_en_in & comparator2_out_pin_choice;
  wire comparator2_output_on_a5 = comparator2_en_in & ~comparator2_out_pin_choice;

  wire lnq_on_a0 = latch_inv_en_in & latch_inv_out_pin_choice;
  wire lnq_on_a5 = latch_inv_en_in & ~latch_inv_out_pin_choice;

  wire pwmb_on_b5 = pwm_b_en_in & pwm_b_pin_choice;
  wire pwmb_on_c0 = pwm_b_en_in & ~pwm_b_pin_choice;

  wire cmp3_on_b5 = cmp3_en_in & cmp3_pin_choice;
  wire cmp3_on_c0 = cmp3_en_in & ~cmp3_pin_choice;

  wire cmp2_on_b3 = cmp2_en_in & cmp2_pin_choice;
  wire cmp2_on_c1 = cmp2_en_in & ~cmp2_pin_choice;

  // Per-pin owner; on a shared pin the higher-ranked peripheral wins.
  // Pins not listed keep plain port behaviour.
  always @* begin
    ovr_en = {W{1'b0}};
    ovr_val = {W{1'b0}};
    // A0 and A5: latch inverted output ranks above comparator 2
    if (lnq_on_a0) begin
      ovr_en[`IOPS_PIN_A0] = 1'b1;
      ovr_val[`IOPS_PIN_A0] = latch_inverted_output_in;
    end else if (comparator2_output_on_a0) begin
      ovr_en[`IOPS_PIN_A0] = 1'b1;
      ovr_val[`IOPS_PIN_A0] = comparator2_output_in;
    end
    if (lnq_on_a5) begin
      ovr_en[`IOPS_PIN_A5] = 1'b1;
      ovr_val[`IOPS_PIN_A5] = latch_inverted_output_in;
    end else if (comparator2_output_on_a5) begin
      ovr_en[`IOPS_PIN_A5] = 1'b1;
      ovr_val[`IOPS_PIN_A5] = comparator2_output_in;
    end
    // B5 and C0: capture/compare 3 ranks above PWM B
    if (cmp3_on_b5) begin
      ovr_en[`IOPS_PIN_B5] = 1'b1;
      ovr_val[`IOPS_PIN_B5] = cmp3_output_in;
    end else if (pwmb_on_b5) begin
      ovr_en[`IOPS_PIN_B5] = 1'b1;
      ovr_val[`IOPS_PIN_B5] = pwm_b_output_in;
    end
    if (cmp3_on_c0) begin
      ovr_en[`IOPS_PIN_C0] = 1'b1;
      ovr_val[`IOPS_PIN_C0] = cmp3_output_in;
    end else if (pwmb_on_c0) begin
      ovr_en[`IOPS_PIN_C0] = 1'b1;
      ovr_val[`IOPS_PIN_C0] = pwm_b_output_in;
    end
    // B3 and C1 carry only capture/compare 2
    if (cmp2_on_b3) begin
      ovr_en[`IOPS_PIN_B3] = 1'b1;
      ovr_val[`IOPS_PIN_B3] = cmp2_output_in;
    end
    if (cmp2_on_c1) begin
      ovr_en[`IOPS_PIN_C1] = 1'b1;
      ovr_val[`IOPS_PIN_C1] = cmp2_output_in;
    end
  end

  iops_pin_sync #(
    .W(W)
  ) iops_pin_sync_inst (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .async_in(pin_i_in),
    .sync_out(pin_sync)
  );

  // Overrides drive as outputs; direction register keeps its value
  iops_port_bits #(
    .W(W)
  ) iops_port_bits_inst (
    .dir_in(dir_all),
    .lat_in(lat_all),
    .ans_in(ans_all),
    .ovr_en_in(ovr_en),
    .ovr_val_in(ovr_val),
    .ovr_oe_in(ovr_en),
    .pin_sync_in(pin_sync),
    .pin_o_out(pin_o_out),
    .pin_oe_out(pin_oe_out),
    .dig_in_out(dig_in)
  );

  // Relocated inputs, registered so they leave the block as data outputs
  reg ss_n_reg;
  reg tgate_reg;
  reg cap2_reg;
  reg cap3_reg;
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      // Slave select rests at its idle, deselected level
      ss_n_reg <= 1'b1;
      tgate_reg <= 1'b0;
      cap2_reg <= 1'b0;
      cap3_reg <= 1'b0;
    end else if (clk_en_in) begin
      // Each input reads only its chosen pin
      ss_n_reg <= slave_select_pin_choice ? dig_in[`IOPS_PIN_A0] : dig_in[`IOPS_PIN_A5];
      // Timer gate: zero picks port B, one picks port C; both captures: one picks port B, zero picks port C
      tgate_reg <= timer_gate_pin_choice ? dig_in[`IOPS_PIN_C4] : dig_in[`IOPS_PIN_B5];
      cap2_reg <= cmp2_pin_choice ? dig_in[`IOPS_PIN_B3] : dig_in[`IOPS_PIN_C1];
      cap3_reg <= cmp3_pin_choice ? dig_in[`IOPS_PIN_B5] : dig_in[`IOPS_PIN_C0];
    end
  end

  assign slave_select_n_out = ss_n_reg;
  assign timer_gate_input_out = tgate_reg;
  assign cmp2_capture_out = cap2_reg;
  assign cmp3_capture_out = cap3_reg;
  assign alt_pin_function_select_out = alt_pin_function_select;
endmodule // iops_top

// ### hw/iops_defines.vh
// Register offsets, field positions, reset values and pin map for the I/O port steering block
`ifndef IOPS_DEFINES_VH
`define IOPS_DEFINES_VH
`define IOPS_NUM_PORTS 5
`define IOPS_PORT_W 8
`define IOPS_ADDR_W 5
// Per port p: base = p*4; +0 pin level, +1 direction, +2 latch, +3 analog select
`define IOPS_OFS_PIN 2'h0
`define IOPS_OFS_DIR 2'h1
`define IOPS_OFS_LAT 2'h2
`define IOPS_OFS_ANS 2'h3
`define IOPS_ADDR_ALTSEL 5'h14
`define IOPS_DIR_RST 8'hff
`define IOPS_LAT_RST 8'h00
`define IOPS_ANS_RST 8'hff
`define IOPS_ALTSEL_RST 8'h00
`define IOPS_ALTSEL_MASK 8'h7f
// Select bit positions
`define IOPS_SEL_CMP2 0
`define IOPS_SEL_SS 1
`define IOPS_SEL_COMPARATOR2_OUTPUT 2
`define IOPS_SEL_LNQ 3
`define IOPS_SEL_PWMB 4
`define IOPS_SEL_TGATE 5
`define IOPS_SEL_CMP3 6
// Flat pin indices: port*8 + bit (A=0,B=1,C=2,D=3,E=4)
`define IOPS_PIN_A0 6'd0
`define IOPS_PIN_A5 6'd5
`define IOPS_PIN_B3 6'd11
`define IOPS_PIN_B5 6'd13
`define IOPS_PIN_C0 6'd16
`define IOPS_PIN_C1 6'd17
`define IOPS_PIN_C4 6'd20
`define IOPS_PIN_D2 6'd26
`endif

// ### hw/iops_pin_sync.v
// Two-flop synchroniser for the raw pin levels
`timescale 1ns/100ps
module iops_pin_sync #(
  parameter W = 40
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire clk_en_in,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else if (clk_en_in) begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule // iops_pin_sync

// ### hw/iops_port_bits.v
// Per-bit pin driver and digital input gating for all ports
`timescale 1ns/100ps
`include "iops_defines.vh"
module iops_port_bits #(
  parameter W = 40
) (
  input wire [W-1:0] dir_in,
  input wire [W-1:0] lat_in,
  input wire [W-1:0] ans_in,
  input wire [W-1:0] ovr_en_in,
  input wire [W-1:0] ovr_val_in,
  input wire [W-1:0] ovr_oe_in,
  input wire [W-1:0] pin_sync_in,
  output wire [W-1:0] pin_o_out,
  output wire [W-1:0] pin_oe_out,
  output wire [W-1:0] dig_in_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // Direction 1 = input, driver off; 0 drives latch
      // Enabled peripheral takes the pin
      assign pin_o_out[i] = ovr_en_in[i] ? ovr_val_in[i] : lat_in[i];
      assign pin_oe_out[i] = ovr_en_in[i] ? ovr_oe_in[i] : ~dir_in[i];
      // Analog select blocks the digital buffer
      assign dig_in_out[i] = pin_sync_in[i] & ~ans_in[i];
    end
  endgenerate
endmodule // iops_port_bits

// ### verif/iops_top_sva.sv
// Port assertions for the I/O port steering block
`timescale 1ns/100ps
module iops_top_sva (
  input wire clk_in,
  input wire sys_rst_in,
  input wire clk_en_in,
  input wire [4:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  input wire [39:0] pin_o_out,
  input wire [39:0] pin_oe_out,
  input wire pwm_b_en_in,
  input wire pwm_b_output_in,
  input wire comparator2_en_in,
  input wire comparator2_output_in,
  input wire cmp2_en_in,
  input wire cmp2_output_in,
  input wire cmp3_en_in,
  input wire cmp3_output_in,
  input wire latch_inv_en_in,
  input wire latch_inverted_output_in,
  input wire [7:0] alt_pin_function_select_out
);
  wire [7:0] sel = alt_pin_function_select_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_TOP_BIT_ZERO: assert property (sel[7] == 1'b0)
    else $error("steering bit 7 set");
  AST_SEL_RESET: assert property ($past(sys_rst_in) && $past(clk_en_in) |-> sel == 8'h00)
    else $error("steering not cleared");
  AST_SEL_WRITE: assert property (clk_en_in && wr_in && addr_in == 5'h14
    |=> sel == ($past(wdata_in) & 8'h7f)) else $error("steering write lost");
  AST_RD_IDLE: assert property (clk_en_in && !rd_in |=> rdata_out == 8'h00)
    else $error("read data outside read slot");
  AST_RD_SEL: assert property (clk_en_in && rd_in && addr_in == 5'h14
    |=> rdata_out == $past(sel)) else $error("steering readback wrong");
  AST_LNQ_ROUTE: assert property (latch_inv_en_in |-> pin_oe_out[sel[3] ? 0 : 5]
    && pin_o_out[sel[3] ? 0 : 5] == latch_inverted_output_in) else $error("latch out route");
  AST_CMP2_ROUTE: assert property (cmp2_en_in |-> pin_oe_out[sel[0] ? 11 : 17]
    && pin_o_out[sel[0] ? 11 : 17] == cmp2_output_in) else $error("cmp2 route");
  AST_CMP3_ROUTE: assert property (cmp3_en_in |-> pin_oe_out[sel[6] ? 13 : 16]
    && pin_o_out[sel[6] ? 13 : 16] == cmp3_output_in) else $error("cmp3 route");
  AST_DIR_RESET: assert property ($past(sys_rst_in) && $past(clk_en_in) |-> !pin_oe_out[39])
    else $error("pin driven after reset");
  AST_PWMB_ROUTE: assert property (pwm_b_en_in
    && !(cmp3_en_in && sel[6] == sel[4])
    |-> pin_oe_out[sel[4] ? 13 : 16] && pin_o_out[sel[4] ? 13 : 16] == pwm_b_output_in)
    else $error("pwm b route");
  AST_COMPARATOR2_OUTPUT_ROUTE: assert property (comparator2_en_in
    && !(latch_inv_en_in && sel[3] == sel[2])
    |-> pin_oe_out[sel[2] ? 0 : 5] && pin_o_out[sel[2] ? 0 : 5] == comparator2_output_in)
    else $error("comparator 2 route");
endmodule // iops_top_sva
bind iops_top iops_top_sva iops_top_sva_inst (.clk_in, .sys_rst_in, .clk_en_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .rdata_out, .pin_o_out, .pin_oe_out, .cmp2_en_in,
  .pwm_b_en_in, .pwm_b_output_in, .comparator2_en_in, .comparator2_output_in,
  .cmp2_output_in, .cmp3_en_in, .cmp3_output_in, .latch_inv_en_in,
  .latch_inverted_output_in, .alt_pin_function_select_out);

// ### verif/iops_pin_model.sv
// Package pin model: each pin level from the block's driver or the board
`timescale 1ns/100ps
module iops_pin_model (
  input wire [39:0] drv_o_in,
  input wire [39:0] drv_oe_in,
  input wire [39:0] board_in,
  output wire [39:0] level_out
);
  // Driven pins read back their own output, so pin reads can differ from the board
  assign level_out = (drv_oe_in & drv_o_in) | (~drv_oe_in & board_in);
endmodule // iops_pin_model

// ### verif/tb_io_port_pin_steering.sv
// Self-checking bench for the I/O port steering block
`timescale 1ns/100ps
module tb_io_port_pin_steering;
  reg clk_in = 1'b0;
  reg sys_rst_in = 1'b1;
  reg [4:0] addr_in = 5'h00;
  reg [7:0] wdata_in = 8'h00;
  reg wr_in = 1'b0;
  reg rd_in = 1'b0;
  reg [9:0] pv = 10'h000;
  reg [39:0] board = 40'hff_ffff_ffff;
  wire [39:0] pin_i, pin_o, pin_oe;
  wire [7:0] rdata, sel;
  wire tgate, ss_n, cap2, cap3;
  integer err_count = 0;
  integer total_checks = 0;
  initial forever #25 clk_in = ~clk_in;
  iops_top iops_top_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
    .pin_i_in(pin_i), .pin_o_out(pin_o), .pin_oe_out(pin_oe), .pwm_b_en_in(pv[0]),
    .pwm_b_output_in(pv[1]), .cmp2_en_in(pv[2]), .cmp2_output_in(pv[3]), .cmp3_en_in(pv[4]),
    .cmp3_output_in(pv[5]), .latch_inv_en_in(pv[6]), .latch_inverted_output_in(pv[7]),
    .comparator2_en_in(pv[8]), .comparator2_output_in(pv[9]), .slave_select_n_out(ss_n),
    .timer_gate_input_out(tgate), .cmp2_capture_out(cap2), .cmp3_capture_out(cap3),
    .alt_pin_function_select_out(sel));
  iops_pin_model iops_pin_model_inst (.drv_o_in(pin_o), .drv_oe_in(pin_oe),
    .board_in(board), .level_out(pin_i));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    begin
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      #1;
    end
  endtask
  task rd(input [4:0] a, input [7:0] e);
    begin
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 chk(rdata, e);
    end
  endtask
  task t_reset;
    begin
      rd(5'h01, 8'hff);
      rd(5'h02, 8'h00);
      rd(5'h03, 8'hff);
      rd(5'h00, 8'h00);
      rd(5'h14, 8'h00);
      rd(5'h15, 8'h00);
      chk(pin_oe[39:32], 8'h00);
    end
  endtask
  task t_latch;
    begin
      wr(5'h00, 8'h5a);
      rd(5'h02, 8'h5a);
      wr(5'h02, 8'h3c);
      wr(5'h03, 8'h00);
      wr(5'h01, 8'h0f);
      chk(pin_oe[7:0], 8'hf0);
      // Pin path is synchronised, so give it a few edges
      repeat (3) @(posedge clk_in);
      rd(5'h00, 8'h3f);
      rd(5'h02, 8'h3c);
    end
  endtask
  task t_sel;
    begin
      wr(5'h14, 8'hff);
      rd(5'h14, 8'h7f);
      rd(5'h01, 8'h0f);
    end
  endtask
  task t_gate;
    begin
      wr(5'h07, 8'h00);
      wr(5'h0b, 8'h00);
      wr(5'h14, 8'h00);
      @(posedge clk_in);
      board[20] <= 1'b0;
      board[11] <= 1'b0;
      board[16] <= 1'b0;
      board[0] <= 1'b0;
      repeat (3) @(posedge clk_in);
      #1 chk({6'h00, tgate, cap2}, 8'h03);
      chk({6'h00, ss_n, cap3}, 8'h02);
      wr(5'h14, 8'h21);
      @(posedge clk_in);
      #1 chk({6'h00, tgate, cap2}, 8'h00);
      chk({6'h00, ss_n, cap3}, 8'h02);
      wr(5'h14, 8'h42);
      @(posedge clk_in);
      #1 chk({6'h00, tgate, cap2}, 8'h03);
      chk({6'h00, ss_n, cap3}, 8'h01);
    end
  endtask
  task t_steer;
    begin
      wr(5'h14, 8'h00);
      @(posedge clk_in);
      pv <= 10'h37f;
      #1 chk({6'h00, pin_oe[17], pin_o[17]}, 8'h03);
      chk({7'h00, pin_oe[11]}, 8'h00);
      chk({7'h00, pin_o[5]}, 8'h00);
      wr(5'h14, 8'h01);
      chk({6'h00, pin_oe[11], pin_o[11]}, 8'h03);
      chk({7'h00, pin_oe[17]}, 8'h00);
      rd(5'h09, 8'hff);
      @(posedge clk_in);
      pv <= 10'h103;
      #1 chk({4'h0, pin_oe[16], pin_o[16], pin_oe[5], pin_o[5]}, 8'h0e);
      wr(5'h14, 8'h14);
      chk({4'h0, pin_oe[13], pin_o[13], pin_oe[0], pin_o[0]}, 8'h0e);
      chk({6'h00, pin_oe[16], pin_o[5]}, 8'h01);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset;
    t_latch;
    t_sel;
    t_gate;
    t_steer;
    tally_and_finish;
  end
  initial begin
    repeat (2000) @(posedge clk_in);
    err_count = err_count + 1;
    tally_and_finish;
  end
endmodule // tb_io_port_pin_steering
